/* File: idp_consts.svh */
// constants for the instrument digital port
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH
// Operation
// [RULE1] a strap picks fault/inhibit, digital I/O or relay link; fault/inhibit default
// [RULE2] fault/inhibit mode pulls the fault line low while a fault is present
// [RULE3] fault/inhibit mode turns the power output off while inhibit is low
// [RULE4] inhibit trips remote-inhibit protection and lights the protection lamp
// [RULE5] inhibit sets the remote-inhibit bit of the questionable event register
// [RULE6] output stays off until inhibit is released and protection is cleared
// [RULE7] fault line is the OR of the three status summary bits
// [RULE8] only enabled events feed the summary bits and the fault line
// [RULE9] fault holds until the cause is gone and the event register is read
// [RULE10] chained fault-to-inhibit wiring shuts every supply without the host
// [RULE11] questionable summary can raise a service request to the host
// [RULE12] inhibit has no effect while the output follows the analog program port
// [RULE13] digital I/O bit weight 1 is an output-only open-collector line
// [RULE14] digital I/O bit weight 2 is an output-only open-collector line
// [RULE15] digital I/O third bit is an input or an open-collector output
// [RULE16] relay mode sends serial relay data on the send line; pin 2 unused
// [RULE17] relay accessory returns relay states serially; device keeps them as status
// [RULE18] a relay command outside relay mode is rejected with an error
// [RULE19] relay mode is not for supplies above 50 amps
// [RULE20] digital I/O holds written data; a port read returns pin levels
// [RULE21] mode strap is static; outputs stay released while in reset
`define IDP_AW          6
`define IDP_CTRL        6'h00
`define IDP_MODE        6'h04
`define IDP_DATA        6'h08
`define IDP_PROT        6'h0C
`define IDP_OPER_EVT    6'h10
`define IDP_OPER_EN     6'h14
`define IDP_QUES_EVT    6'h18
`define IDP_QUES_EN     6'h1C
`define IDP_ESR_EVT     6'h20
`define IDP_ESR_EN      6'h24
`define IDP_RELAY       6'h28
`define IDP_SUMMARY     6'h2C
`define IDP_MODE_FLT    2'h0
`define IDP_MODE_DIO    2'h1
`define IDP_MODE_RLY    2'h2
`define IDP_DATA_RST    3'h7
`define IDP_RI_BIT      3
`define IDP_CTRL_IO2    0
`define IDP_CTRL_SRQ    1
`define IDP_CFG_WAIT    2'h3
`define IDP_CLK_NS      40
`define IDP_RLY_BIT_NS  1000
`define IDP_RLY_BIT_CYC ((`IDP_RLY_BIT_NS + `IDP_CLK_NS - 1) / `IDP_CLK_NS)
`endif

/* File: idp_pkg.sv */
// types for the instrument digital port
`include "idp_consts.svh"
package idp_pkg;
   typedef enum logic [1:0] {IDP_RLY_IDLE, IDP_RLY_START, IDP_RLY_DATA, IDP_RLY_STOP} idp_rly_st_t;
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [`IDP_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } idp_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } idp_apb_rsp_t;
endpackage

/* File: idp_port.sv */
// four-pin digital port with status summary, inhibit and relay link
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "idp_consts.svh"
module idp_port #(
   parameter int EVW   = 8,
   parameter int RLY_W = 8
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire idp_pkg::idp_apb_req_t apb_req,
   output var  idp_pkg::idp_apb_rsp_t apb_rsp,
   input  wire logic [1:0]            mode_strap,
   input  wire logic                  ext_prog_strap,
   input  wire logic [EVW-1:0]        oper_evt_in,
   input  wire logic [EVW-1:0]        ques_evt_in,
   input  wire logic [EVW-1:0]        esr_evt_in,
   input  wire logic [2:0]            pin_in,
   output var  logic                  pin1_oe,
   output var  logic                  pin2_oe,
   output var  logic                  pin3_out,
   output var  logic                  pin3_oe,
   output var  logic                  power_out_en,
   output var  logic                  prot_led,
   output var  logic                  srq
);
   import idp_pkg::*;

   localparam int BIT_CYC = `IDP_RLY_BIT_CYC;
   localparam int CW      = $clog2(BIT_CYC + 1);
   localparam int BW      = $clog2(RLY_W + 1);

   function automatic logic summ(input logic [EVW-1:0] ev, input logic [EVW-1:0] en);
      summ = |(ev & en);
   endfunction

   // ***************************************************
   // pin synchronisers and configuration capture
   // ***************************************************
   logic [2:0] pin_m_ff;
   logic [2:0] pin_s_ff;
   logic [2:0] cfg_m_ff;
   logic [2:0] cfg_s_ff;
   logic [1:0] cfg_cnt_ff;
   logic [1:0] mode_ff;
   logic       ext_prog_ff;
   logic       cfg_done;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_m_ff <= 3'h7;
         pin_s_ff <= 3'h7;
         cfg_m_ff <= 3'h0;
         cfg_s_ff <= 3'h0;
      end
      else
      begin
         pin_m_ff <= pin_in;
         pin_s_ff <= pin_m_ff;
         cfg_m_ff <= {ext_prog_strap, mode_strap};
         cfg_s_ff <= cfg_m_ff;
      end
   end

   assign cfg_done = (cfg_cnt_ff == `IDP_CFG_WAIT);

   // strap caught once the synchroniser holds a real sample; jumper is static
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_cnt_ff  <= 2'h0;
         mode_ff     <= `IDP_MODE_FLT;
         ext_prog_ff <= 1'b0;
      end
      else if (!cfg_done)
      begin
         cfg_cnt_ff <= cfg_cnt_ff + 2'h1;
         if (cfg_cnt_ff == 2'h2)
         begin
            // illegal code falls back to the factory function
            mode_ff     <= (cfg_s_ff[1:0] == 2'h3) ? `IDP_MODE_FLT : cfg_s_ff[1:0]; // [RULE1] [RULE21]
            ext_prog_ff <= cfg_s_ff[2];
         end
      end
   end

   wire is_flt = cfg_done && (mode_ff == `IDP_MODE_FLT);
   wire is_dio = cfg_done && (mode_ff == `IDP_MODE_DIO);
   wire is_rly = cfg_done && (mode_ff == `IDP_MODE_RLY);
   wire inh_act = is_flt && !pin_s_ff[2] && !ext_prog_ff; // [RULE3] [RULE12]

   // ***************************************************
   // bus access decode
   // ***************************************************
   idp_apb_rsp_t rsp_ff;
   idp_apb_rsp_t nxt_rsp;
   assign apb_rsp = rsp_ff;

   wire acc   = apb_req.psel && apb_req.penable && rsp_ff.pready;
   wire wr    = acc && apb_req.pwrite;
   wire rd    = acc && !apb_req.pwrite;
   wire [`IDP_AW-1:0] adr = apb_req.paddr;

   // ***************************************************
   // status events, enables and summaries
   // ***************************************************
   logic [2:0][EVW-1:0] evt_ff;
   logic [2:0][EVW-1:0] en_ff;
   logic [2:0][EVW-1:0] src;
   logic [2:0][`IDP_AW-1:0] evt_adr;
   logic [2:0][`IDP_AW-1:0] en_adr;
   logic [2:0] sum;

   always_comb
   begin
      src          = {esr_evt_in, ques_evt_in, oper_evt_in};
      src[1][`IDP_RI_BIT] = ques_evt_in[`IDP_RI_BIT] | inh_act; // [RULE5]
      evt_adr      = {`IDP_ESR_EVT, `IDP_QUES_EVT, `IDP_OPER_EVT};
      en_adr       = {`IDP_ESR_EN, `IDP_QUES_EN, `IDP_OPER_EN};
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_stat
         // a read clears, but an event in the same cycle survives
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               evt_ff[g] <= '0;
            else if (rd && adr == evt_adr[g])
               evt_ff[g] <= src[g]; // [RULE9]
            else
               evt_ff[g] <= evt_ff[g] | src[g];
         end
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               en_ff[g] <= '0;
            else if (wr && adr == en_adr[g])
               en_ff[g] <= apb_req.pwdata[EVW-1:0];
         end
         assign sum[g] = summ(evt_ff[g], en_ff[g]); // [RULE8]
      end
   endgenerate

   wire fault = |sum; // [RULE7]

   // ***************************************************
   // control, data and protection
   // ***************************************************
   logic [1:0] ctrl_ff;
   logic [2:0] data_ff;
   logic       prot_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff <= 2'h0;
         data_ff <= `IDP_DATA_RST;
      end
      else
      begin
         if (wr && adr == `IDP_CTRL)
            ctrl_ff <= apb_req.pwdata[1:0];
         if (wr && adr == `IDP_DATA)
            data_ff <= apb_req.pwdata[2:0]; // [RULE20]
      end
   end

   // trip wins over a clear issued while inhibit is still held
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prot_ff <= 1'b0;
      else if (inh_act)
         prot_ff <= 1'b1; // [RULE4]
      else if (wr && adr == `IDP_PROT && apb_req.pwdata[0])
         prot_ff <= 1'b0; // [RULE6]
   end

   // ***************************************************
   // relay link serialiser
   // ***************************************************
   idp_rly_st_t       st_ff;
   logic [CW-1:0]     cyc_ff;
   logic [BW-1:0]     bit_ff;
   logic [RLY_W-1:0]  tx_ff;
   logic [RLY_W-1:0]  rx_ff;
   logic [RLY_W-1:0]  rly_stat_ff;
   logic              rly_err_ff;
   logic              tx_line;

   wire rly_wr  = wr && adr == `IDP_RELAY;
   wire bit_end = (cyc_ff == CW'(BIT_CYC - 1));
   wire busy    = (st_ff != IDP_RLY_IDLE);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff  <= IDP_RLY_IDLE;
         cyc_ff <= '0;
         bit_ff <= '0;
         tx_ff  <= '0;
         rx_ff  <= '0;
      end
      else
      begin
         cyc_ff <= (st_ff == IDP_RLY_IDLE || bit_end) ? '0 : cyc_ff + CW'(1);
         unique case (st_ff)
            IDP_RLY_IDLE:
               if (rly_wr && is_rly && !busy)
               begin
                  tx_ff <= apb_req.pwdata[RLY_W-1:0]; // [RULE16]
                  st_ff <= IDP_RLY_START;
               end
            IDP_RLY_START:
               if (bit_end)
               begin
                  bit_ff <= '0;
                  st_ff  <= IDP_RLY_DATA;
               end
            IDP_RLY_DATA:
               if (bit_end)
               begin
                  // return line sampled at the end of each bit, lsb first
                  rx_ff  <= {pin_s_ff[2], rx_ff[RLY_W-1:1]}; // [RULE17]
                  tx_ff  <= tx_ff >> 1;
                  bit_ff <= bit_ff + BW'(1);
                  if (bit_ff == BW'(RLY_W - 1))
                     st_ff <= IDP_RLY_STOP;
               end
            IDP_RLY_STOP:
               if (bit_end)
                  st_ff <= IDP_RLY_IDLE;
         endcase
      end
   end

   // status and error flags; a new error beats a clearing read
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rly_stat_ff <= '0;
         rly_err_ff  <= 1'b0;
      end
      else
      begin
         if (st_ff == IDP_RLY_STOP && bit_end)
            rly_stat_ff <= rx_ff;
         if (rly_wr && (!is_rly || busy))
            rly_err_ff <= 1'b1; // [RULE18]
         else if (rd && adr == `IDP_RELAY)
            rly_err_ff <= 1'b0;
      end
   end

   always_comb
   begin
      unique case (st_ff)
         IDP_RLY_START: tx_line = 1'b0;
         IDP_RLY_DATA:  tx_line = tx_ff[0];
         default:       tx_line = 1'b1;
      endcase
   end

   // ***************************************************
   // register read mux and bus answer
   // ***************************************************
   always_comb
   begin
      nxt_rsp        = '0;
      nxt_rsp.pready = apb_req.psel && apb_req.penable && !rsp_ff.pready;
      unique case (adr)
         `IDP_CTRL:     nxt_rsp.prdata[1:0] = ctrl_ff;
         `IDP_MODE:     nxt_rsp.prdata[2:0] = {ext_prog_ff, mode_ff};
         `IDP_DATA:     nxt_rsp.prdata[2:0] = pin_s_ff; // [RULE20]
         `IDP_PROT:     nxt_rsp.prdata[1:0] = {inh_act, prot_ff};
         `IDP_OPER_EVT: nxt_rsp.prdata[EVW-1:0] = evt_ff[0];
         `IDP_OPER_EN:  nxt_rsp.prdata[EVW-1:0] = en_ff[0];
         `IDP_QUES_EVT: nxt_rsp.prdata[EVW-1:0] = evt_ff[1];
         `IDP_QUES_EN:  nxt_rsp.prdata[EVW-1:0] = en_ff[1];
         `IDP_ESR_EVT:  nxt_rsp.prdata[EVW-1:0] = evt_ff[2];
         `IDP_ESR_EN:   nxt_rsp.prdata[EVW-1:0] = en_ff[2];
         `IDP_RELAY:    nxt_rsp.prdata[RLY_W+1:0] = {rly_err_ff, busy, rly_stat_ff};
         `IDP_SUMMARY:  nxt_rsp.prdata[3:0] = {fault, sum};
         default:       nxt_rsp.pslverr = nxt_rsp.pready;
      endcase
      if (apb_req.pwrite)
         nxt_rsp.prdata = '0;
      // relay command refused outside relay mode or mid-frame
      if (apb_req.pwrite && adr == `IDP_RELAY && (!is_rly || busy))
         nxt_rsp.pslverr = nxt_rsp.pready; // [RULE18]
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rsp_ff <= '0;
      else
         rsp_ff <= nxt_rsp;
   end

   // ***************************************************
   // pin and output drivers
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin1_oe      <= 1'b0; // [RULE21]
         pin2_oe      <= 1'b0;
         pin3_out     <= 1'b0;
         pin3_oe      <= 1'b0;
         power_out_en <= 1'b0;
         prot_led     <= 1'b0;
         srq          <= 1'b0;
      end
      else
      begin
         // a low fault line feeds the next supply's inhibit directly
         pin1_oe      <= (is_flt && fault) || (is_dio && !data_ff[0]) || (is_rly && !tx_line); // [RULE2] [RULE10] [RULE13]
         pin2_oe      <= is_dio && !data_ff[1]; // [RULE14]
         pin3_out     <= 1'b0;
         pin3_oe      <= is_dio && ctrl_ff[`IDP_CTRL_IO2] && !data_ff[2]; // [RULE15]
         power_out_en <= cfg_done && !inh_act && !prot_ff; // [RULE3] [RULE6]
         prot_led     <= prot_ff || inh_act; // [RULE4]
         srq          <= ctrl_ff[`IDP_CTRL_SRQ] && sum[1]; // [RULE11]
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   property p_inh_off;
      @(posedge pclk) disable iff (!presetn)
      inh_act |=> !power_out_en;
   endproperty
   a_inh_off: assert property (p_inh_off) else $error("output on while inhibited"); // [RULE3]

   property p_prot_hold;
      @(posedge pclk) disable iff (!presetn)
      (prot_ff && !(wr && adr == `IDP_PROT)) |=> prot_ff;
   endproperty
   a_prot_hold: assert property (p_prot_hold) else $error("protection dropped without clear"); // [RULE6]

   property p_prot_set;
      @(posedge pclk) disable iff (!presetn)
      inh_act |=> prot_ff ##1 prot_led;
   endproperty
   a_prot_set: assert property (p_prot_set) else $error("inhibit did not trip"); // [RULE4]

   property p_ri_bit;
      @(posedge pclk) disable iff (!presetn)
      inh_act |=> evt_ff[1][`IDP_RI_BIT];
   endproperty
   a_ri_bit: assert property (p_ri_bit) else $error("remote-inhibit event missing"); // [RULE5]

   property p_fault_pin;
      @(posedge pclk) disable iff (!presetn)
      (is_flt && |sum) |=> pin1_oe;
   endproperty
   a_fault_pin: assert property (p_fault_pin) else $error("fault line not pulled"); // [RULE2]

   property p_fault_or;
      @(posedge pclk) disable iff (!presetn)
      is_flt && $stable(is_flt) |=> pin1_oe == $past(fault);
   endproperty
   a_fault_or: assert property (p_fault_or) else $error("fault line not OR of summaries"); // [RULE7]

   property p_ext_prog;
      @(posedge pclk) disable iff (!presetn)
      (ext_prog_ff && cfg_done && !prot_ff) |=> power_out_en;
   endproperty
   a_ext_prog: assert property (p_ext_prog) else $error("inhibit acted on analog programmed output"); // [RULE12]

   property p_rly_err;
      @(posedge pclk) disable iff (!presetn)
      (rly_wr && !is_rly) |=> rly_err_ff && st_ff == IDP_RLY_IDLE;
   endproperty
   a_rly_err: assert property (p_rly_err) else $error("relay command outside relay mode accepted"); // [RULE18]

   property p_dio_b2;
      @(posedge pclk) disable iff (!presetn)
      (is_dio && $stable(data_ff)) |=> pin2_oe == !$past(data_ff[1]);
   endproperty
   a_dio_b2: assert property (p_dio_b2) else $error("bit weight 2 line wrong"); // [RULE14]

   property p_rly_frame;
      @(posedge pclk) disable iff (!presetn)
      $rose(busy) |-> busy[*8];
   endproperty
   a_rly_frame: assert property (p_rly_frame) else $error("relay frame cut short"); // [RULE16]
endmodule
`default_nettype wire

/* File: idp_far.sv */
// far-side model: external switch, io2 driver, chained supply and relay accessory
`timescale 1ns/1ps
`default_nettype none
module idp_far #(
   parameter int         BIT = 25,
   parameter logic [7:0] ST0 = 8'hA5
) (
   input  wire logic       pclk,
   input  wire logic [1:0] mode,
   input  wire logic       pin1_oe,
   input  wire logic       pin2_oe,
   input  wire logic       pin3_oe,
   input  wire logic       inh_n,
   input  wire logic       io2_ext,
   input  wire logic       chain,
   output var  logic [2:0] pin_in,
   output var  logic [7:0] got
);
   logic       act = 1'b0;
   int         cnt = 0;
   int         idx;
   logic [7:0] st = ST0;
   logic [7:0] sh;
   // ***********************
   // pin levels, pulled up when released
   // ***********************
   always_comb
   begin
      idx = cnt / BIT - 1;
      pin_in[0] = ~pin1_oe;
      pin_in[1] = ~pin2_oe;
      case (mode)
         2'h1: pin_in[2] = ~pin3_oe & io2_ext;
         2'h2: pin_in[2] = (act && idx >= 0 && idx < 8) ? st[idx[2:0]] : 1'b1;
         default: pin_in[2] = inh_n & ~(chain & pin1_oe);
      endcase
   end
   // ***********************
   // accessory: mid-bit sampling, old state returned lsb first
   // ***********************
   always @(posedge pclk)
   begin
      if (!act)
      begin
         if (mode == 2'h2 && pin1_oe)
         begin
            act <= 1'b1;
            cnt <= 1;
         end
      end
      else
      begin
         cnt <= cnt + 1;
         if (cnt % BIT == BIT / 2 && idx >= 0 && idx < 8)
            sh[idx] <= ~pin1_oe;
         if (cnt == 10 * BIT - 1)
         begin
            act <= 1'b0;
            st <= sh;
            got <= sh;
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the instrument digital port
`timescale 1ns/1ps
`default_nettype none
`include "idp_consts.svh"
module testbench;
   import idp_pkg::*;
   logic         pclk = 1'b0;
   logic         presetn;
   idp_apb_req_t req;
   idp_apb_rsp_t rsp;
   logic [1:0]   mode_strap;
   logic         ext_prog;
   logic [7:0]   ev [3];
   logic [2:0]   pin_in;
   logic         p1_oe, p2_oe, p3_out, p3_oe, pwr, led, srq;
   logic         inh_n, io2_ext, chain;
   logic [7:0]   got, prev, v;
   logic [31:0]  rv;
   logic         re;
   logic [15:0]  rnd;
   logic [5:0]   ea;
   int           k;
   int           n_fail = 0;
   int           n_compared = 0;

   always #20 pclk = ~pclk;

   idp_port uut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .mode_strap(mode_strap),
      .ext_prog_strap(ext_prog), .oper_evt_in(ev[0]), .ques_evt_in(ev[1]), .esr_evt_in(ev[2]),
      .pin_in(pin_in), .pin1_oe(p1_oe), .pin2_oe(p2_oe), .pin3_out(p3_out), .pin3_oe(p3_oe),
      .power_out_en(pwr), .prot_led(led), .srq(srq));
   idp_far far (.pclk(pclk), .mode(mode_strap), .pin1_oe(p1_oe), .pin2_oe(p2_oe), .pin3_oe(p3_oe),
      .inh_n(inh_n), .io2_ext(io2_ext), .chain(chain), .pin_in(pin_in), .got(got));

   // ***********************
   // helpers
   // ***********************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // readback: io2 shows the wired-and of data and outside level when io2 output is enabled, else the outside level alone
   function automatic logic [31:0] pexp(input logic [2:0] d, input logic en, input logic x);
      return {29'h0, en ? (d[2] & x) : x, d[1], d[0]};
   endfunction
   task automatic print_verdict();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
      int t;
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (rsp.pready !== 1'b1 && t < 20);
      if (t >= 20)
      begin
         n_fail++;
         print_verdict();
      end
      rv = rsp.prdata;
      re = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rc(input logic [5:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask
   task automatic rst(input logic [1:0] m);
      presetn <= 1'b0;
      mode_strap <= m;
      cyc(3);
      chk({p1_oe, p2_oe, p3_oe, p3_out, pwr, led, srq}, 0);
      presetn <= 1'b1;
      cyc(6);
   endtask

   // ***********************
   // main sequence
   // ***********************
   initial
   begin
      req = '0;
      presetn = 1'b0;
      mode_strap = 2'h0;
      ext_prog = 1'b0;
      ev[0] = 8'h00;
      ev[1] = 8'h00;
      ev[2] = 8'h00;
      inh_n = 1'b1;
      io2_ext = 1'b1;
      chain = 1'b0;
      rnd = 16'h0D30;
      cyc(1);
      rst(`IDP_MODE_FLT);
      chk(pwr, 1);
      rc(`IDP_MODE, 0);
      apb(1'b0, 6'h30, 32'h0);
      chk(re, 1);
      apb(1'b1, `IDP_RELAY, 32'h3C);
      chk(re, 1);
      apb(1'b1, `IDP_CTRL, 32'h2);
      for (int g = 0; g < 3; g++)
      begin
         rnd = lfsr(rnd);
         k = rnd[2:0];
         v = rnd[15:8] | (8'h01 << k);
         ea = 6'h10 + 6'(8 * g);
         ev[g] <= v;
         cyc(1);
         ev[g] <= 8'h00;
         cyc(3);
         chk(p1_oe, 0);
         apb(1'b1, ea + 6'h4, 32'(1 << k));
         cyc(2);
         chk(p1_oe, 1);
         rc(`IDP_SUMMARY, 32'((1 << g) | 8));
         chk(srq, g == 1);
         rc(ea, {24'h0, v});
         cyc(2);
         chk(p1_oe, 0);
         apb(1'b1, ea + 6'h4, 32'h0);
      end
      // switch closed, cleared while held, then released before a second clear
      inh_n <= 1'b0;
      cyc(5);
      chk(pwr, 0);
      chk(led, 1);
      rc(`IDP_QUES_EVT, 32'h8);
      apb(1'b1, `IDP_PROT, 32'h1);
      cyc(2);
      chk(pwr, 0);
      inh_n <= 1'b1;
      cyc(5);
      chk(pwr, 0);
      apb(1'b1, `IDP_PROT, 32'h1);
      cyc(3);
      chk(pwr, 1);
      chain <= 1'b1;
      apb(1'b1, `IDP_OPER_EN, 32'h1);
      ev[0] <= 8'h01;
      cyc(1);
      ev[0] <= 8'h00;
      cyc(6);
      chk(pwr, 0);
      chain <= 1'b0;
      apb(1'b0, `IDP_OPER_EVT, 32'h0);
      apb(1'b1, `IDP_OPER_EN, 32'h0);
      cyc(4);
      apb(1'b1, `IDP_PROT, 32'h1);
      // strap is only caught after reset, so reset again with it set
      ext_prog <= 1'b1;
      rst(`IDP_MODE_FLT);
      rc(`IDP_MODE, 32'h4);
      inh_n <= 1'b0;
      cyc(5);
      chk(pwr, 1);
      inh_n <= 1'b1;
      ext_prog <= 1'b0;
      rst(`IDP_MODE_DIO);
      rc(`IDP_MODE, 1);
      for (int i = 0; i < 6; i++)
      begin
         rnd = lfsr(rnd);
         io2_ext <= rnd[3] | rnd[4];
         apb(1'b1, `IDP_CTRL, {31'h0, rnd[3]});
         apb(1'b1, `IDP_DATA, {29'h0, rnd[2:0]});
         cyc(3);
         chk(p1_oe, !rnd[0]);
         chk(p2_oe, !rnd[1]);
         chk(p3_oe, rnd[3] & !rnd[2]);
         rc(`IDP_DATA, pexp(rnd[2:0], rnd[3], rnd[3] | rnd[4]));
      end
      // modelled supply stays within the relay link current limit
      rst(`IDP_MODE_RLY);
      rc(`IDP_MODE, 2);
      prev = 8'hA5;
      for (int i = 0; i < 3; i++)
      begin
         rnd = lfsr(rnd);
         apb(1'b1, `IDP_RELAY, {24'h0, rnd[7:0]});
         apb(1'b1, `IDP_RELAY, 32'h0);
         chk(re, 1);
         chk(p2_oe, 0);
         k = 0;
         do
         begin
            cyc(10);
            apb(1'b0, `IDP_RELAY, 32'h0);
            k++;
         end
         while (rv[8] !== 1'b0 && k < 40);
         if (k >= 40)
         begin
            n_fail++;
            print_verdict();
         end
         chk(got, rnd[7:0]);
         chk(rv[7:0], prev);
         prev = rnd[7:0];
      end
      print_verdict();
   end
endmodule
`default_nettype wire
